/* File: logic/crpr_readout.sv */
// Calibration pattern readout path of a x16 DDR3 device
//
// Function
// - Mode set to register three with bit 2 high enters pattern mode.
// - In pattern mode every read type is served from the pattern store.
// - Two-bit location field of register three picks the pattern location.
// - Read with autoprecharge acts as a plain read; no precharge performed.
// - Device reset is honoured while pattern mode is on.
// - Pattern enable low: location ignored, reads and writes use the array.
// - Pattern on bit 0 of both lanes; other bits copy it or zero.
// - Eight-beat pattern reads use column bit 2 low, beats 0 to 7.
// - Chopped reads return beats 0-3 for bit 2 low, 4-7 for high.
// - Bit 12 chops on the fly only if enabled; fixed chop applies too.
// - Bank bits and other column bits are ignored on pattern reads.
// - Pattern data use the same read latency as array reads.
// - Beat 0 is the location's LSB, beat 7 its MSB.
// - Location zero returns alternating zero and one, starting with zero.
`timescale 1ns/100ps
module crpr_readout
  import crpr_pkg::*;
#(
  parameter int RD_LAT    = RD_LAT_DEF,
  parameter bit REPLICATE = 1'b1
) (
  // Clock and device reset
  input  wire logic              MCLK,
  input  wire logic              RESET_N,
  // Command and address pins
  input  crpr_cmd_t              CMD,
  // Data pins, two byte lanes
  input  wire logic [15:0]       DQ_IN,
  output logic      [15:0]       DQ_OUT,
  output logic                   DQ_OE,
  // Array side strobes
  output logic                   ARRAY_RD,
  output logic                   ARRAY_WR,
  output logic                   ARRAY_AUTOPRE,
  output logic      [15:0]       ARRAY_WDATA,
  // Array read data returning for the pins
  input  wire logic [15:0]       ARRAY_DQ,
  input  wire logic              ARRAY_DQ_VLD,
  // Status
  output logic                   PATTERN_MODE
);

  initial begin
    if (RD_LAT < 1 || RD_LAT > 64) begin
      $error("crpr_readout: RD_LAT must lie in 1..64");
    end
  end

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b01,
    ST_BURST = 2'b10
  } crpr_state_t;

  // Mode registers and datapath state
  logic [ADDR_W-1:0] mr_zero_q;
  logic [ADDR_W-1:0] mr_three_q;
  crpr_pipe_t        pipe_q [RD_LAT];
  crpr_pipe_t        pipe_in;
  crpr_state_t       state_q;
  crpr_state_t       state_d;
  logic [2:0]        beat_q;
  logic [3:0]        left_q;
  logic [15:0]       dq_q;
  logic              oe_q;
  logic              rd_q;
  logic              wr_q;
  logic              ap_q;
  logic [15:0]       wdata_q;
  logic [7:0]        pat_byte;

  // Command decode
  logic              cmd_on;
  logic              is_mode_set;
  logic              is_read;
  logic              is_write;
  logic              pat_en;
  logic              want_chop;
  logic              load;
  crpr_pipe_t        pipe_out;
  logic [2:0]        start_beat;
  logic [3:0]        burst_len;
  logic              cur_bit;
  logic [15:0]       lanes;

  assign cmd_on      = !CMD.cs_n;
  assign is_mode_set = cmd_on && ({CMD.ras_n, CMD.cas_n, CMD.we_n} == CMD_MODE_SET);
  assign is_read     = cmd_on && ({CMD.ras_n, CMD.cas_n, CMD.we_n} == CMD_READ);
  assign is_write    = cmd_on && ({CMD.ras_n, CMD.cas_n, CMD.we_n} == CMD_WRITE);
  assign pat_en      = mr_three_q[PAT_EN_BIT];

  // Chop decision: fixed four, or on the fly with the chop bit low
  always_comb begin
    unique case (mr_zero_q[BL_LSB +: BL_W])
      BL_FIXED_FOUR: want_chop = 1'b1;
      BL_ON_THE_FLY: want_chop = !CMD.addr[CHOP_BIT];
      default:       want_chop = 1'b0;
    endcase
  end

  // Pattern read entering the latency pipe; only bits 2 and 12 matter
  always_comb begin
    pipe_in       = '0;
    pipe_in.vld   = is_read && pat_en;
    pipe_in.chop  = want_chop;
    pipe_in.upper = want_chop && CMD.addr[NIBBLE_BIT];
  end

  // Mode registers; device reset clears pattern mode at any time
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      mr_zero_q  <= MR_ZERO_RST;
      mr_three_q <= MR_THREE_RST;
    end else if (is_mode_set) begin
      if (CMD.ba == MR_SEL_ZERO) begin
        mr_zero_q <= CMD.addr;
      end
      if (CMD.ba == MR_SEL_THREE) begin
        mr_three_q <= CMD.addr;
      end
    end
  end

  // Read latency pipe, same depth as an array read takes
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      pipe_q[0] <= '0;
    end else begin
      pipe_q[0] <= pipe_in;
    end
  end

  for (genvar s = 1; s < RD_LAT; s++) begin : g_pipe
    always_ff @(posedge MCLK or negedge RESET_N) begin
      if (!RESET_N) begin
        pipe_q[s] <= '0;
      end else begin
        pipe_q[s] <= pipe_q[s-1];
      end
    end
  end

  assign pipe_out   = pipe_q[RD_LAT-1];
  assign load       = pipe_out.vld;
  assign start_beat = pipe_out.upper ? UPPER_START : 3'h0;
  assign burst_len  = pipe_out.chop ? BEATS_FOUR : BEATS_EIGHT;

  // Pattern store addressed by the location field
  crpr_pattern_mem #(
    .LOCS (PAT_LOCS)
  ) u_mem (
    .clk   (MCLK),
    .rst_n (RESET_N),
    .addr  (mr_three_q[LOC_LSB +: LOC_W]),
    .rdata (pat_byte)
  );

  // Beat n of the burst is bit n of the selected location
  assign cur_bit = load ? pat_byte[start_beat] : pat_byte[beat_q];

  // Each lane carries the beat on bit 0, upper bits copy or stay low
  for (genvar l = 0; l < 2; l++) begin : g_lane
    assign lanes[8*l]         = cur_bit;
    assign lanes[8*l+7:8*l+1] = REPLICATE ? {7{cur_bit}} : 7'h00;
  end

  // Burst sequencing; a new burst arriving mid-burst takes over
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE: begin
        if (load) begin
          state_d = ST_BURST;
        end
      end
      ST_BURST: begin
        if (!load && left_q == 4'h0) begin
          state_d = ST_IDLE;
        end
      end
      default: state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // Beat pointer and beats still to go
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      beat_q <= 3'h0;
      left_q <= 4'h0;
    end else if (load) begin
      beat_q <= start_beat + 3'h1;
      left_q <= burst_len - 4'h1;
    end else if (state_q == ST_BURST && left_q != 4'h0) begin
      beat_q <= beat_q + 3'h1;
      left_q <= left_q - 4'h1;
    end
  end

  // Pin drive: pattern beats first, else array data returning outside pattern mode
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      dq_q <= 16'h0000;
      oe_q <= 1'b0;
    end else if (load || (state_q == ST_BURST && left_q != 4'h0)) begin
      dq_q <= lanes;
      oe_q <= 1'b1;
    end else if (ARRAY_DQ_VLD && !pat_en) begin
      dq_q <= ARRAY_DQ;
      oe_q <= 1'b1;
    end else begin
      dq_q <= 16'h0000;
      oe_q <= 1'b0;
    end
  end

  // Array strobes only outside pattern mode, so no precharge leaks out
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rd_q    <= 1'b0;
      wr_q    <= 1'b0;
      ap_q    <= 1'b0;
      wdata_q <= 16'h0000;
    end else begin
      rd_q    <= is_read && !pat_en;
      wr_q    <= is_write && !pat_en;
      ap_q    <= (is_read || is_write) && !pat_en && CMD.addr[AP_BIT];
      wdata_q <= DQ_IN;
    end
  end

  // Outputs straight from flops
  assign DQ_OUT        = dq_q;
  assign DQ_OE         = oe_q;
  assign ARRAY_RD      = rd_q;
  assign ARRAY_WR      = wr_q;
  assign ARRAY_AUTOPRE = ap_q;
  assign ARRAY_WDATA   = wdata_q;
  assign PATTERN_MODE  = pat_en;

endmodule

/* File: shared/crpr_pkg.sv */
// Shared constants and carrier types for the calibration pattern readout
package crpr_pkg;

  // Command pin decode values {ras_n, cas_n, we_n} with chip select low
  localparam logic [2:0] CMD_MODE_SET = 3'h0;
  localparam logic [2:0] CMD_READ     = 3'h5;
  localparam logic [2:0] CMD_WRITE    = 3'h4;

  // Bank address values that select a mode register on a mode set
  localparam logic [2:0] MR_SEL_ZERO  = 3'h0;
  localparam logic [2:0] MR_SEL_THREE = 3'h3;

  // Address and mode field positions
  localparam int ADDR_W      = 14;
  localparam int PAT_EN_BIT  = 2;   // Pattern enable in mode_register_three
  localparam int LOC_LSB     = 0;   // pattern_location_sel field
  localparam int LOC_W       = 2;
  localparam int BL_LSB      = 0;   // Burst length field in mode_register_zero
  localparam int BL_W        = 2;
  localparam int NIBBLE_BIT  = 2;   // Column bit picking the chopped half
  localparam int AP_BIT      = 10;  // autoprecharge_bit
  localparam int CHOP_BIT    = 12;  // chop_select_bit, low selects a chop

  // Burst length field encodings
  localparam logic [1:0] BL_FIXED_EIGHT = 2'h0;
  localparam logic [1:0] BL_ON_THE_FLY  = 2'h1;
  localparam logic [1:0] BL_FIXED_FOUR  = 2'h2;

  // Reset values of the mode registers
  localparam logic [ADDR_W-1:0] MR_ZERO_RST  = 14'h0000;
  localparam logic [ADDR_W-1:0] MR_THREE_RST = 14'h0000;

  // Burst shape
  localparam logic [3:0] BEATS_EIGHT = 4'h8;
  localparam logic [3:0] BEATS_FOUR  = 4'h4;
  localparam logic [2:0] UPPER_START = 3'h4;

  // Pattern store contents, bit n is beat n
  localparam int         PAT_LOCS   = 4;
  localparam logic [7:0] PAT_CALIB  = 8'haa;
  localparam logic [7:0] PAT_RSVD   = 8'h00;

  // Default read latency in clock cycles
  localparam int RD_LAT_DEF = 11;

  // Command and address pins as sampled on a rising edge
  typedef struct packed {
    logic              cs_n;
    logic              ras_n;
    logic              cas_n;
    logic              we_n;
    logic [2:0]        ba;
    logic [ADDR_W-1:0] addr;
  } crpr_cmd_t;

  // One pattern read travelling down the latency pipe
  typedef struct packed {
    logic vld;
    logic chop;
    logic upper;
  } crpr_pipe_t;

endpackage

/* File: logic/crpr_pattern_mem.sv */
// Small pattern store with registered read data
`timescale 1ns/100ps
module crpr_pattern_mem
  import crpr_pkg::*;
#(
  parameter int LOCS = PAT_LOCS
) (
  // Clock and reset
  input  wire logic                    clk,
  input  wire logic                    rst_n,
  // Read port
  input  wire logic [$clog2(LOCS)-1:0] addr,
  output logic      [7:0]              rdata
);

  // One location would leave a zero-width address port
  if (LOCS < 2) begin : g_bad_locs
    $error("crpr_pattern_mem: LOCS must be at least two");
  end

  logic [7:0] table_w [LOCS];

  // Location zero is the calibration pattern, the rest are reserved
  for (genvar g = 0; g < LOCS; g++) begin : g_loc
    assign table_w[g] = (g == 0) ? PAT_CALIB : PAT_RSVD;
  end

  // Registered read data
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= 8'h00;
    end else begin
      rdata <= table_w[addr];
    end
  end

endmodule

/* File: sim/crpr_readout_asserts.sv */
// Port checker for the calibration pattern readout
`timescale 1ns/100ps
module crpr_readout_asserts
  import crpr_pkg::*;
#(
  parameter int RD_LAT    = RD_LAT_DEF,
  parameter bit REPLICATE = 1'b1
) (
  // Clock and reset
  input wire logic        MCLK,
  input wire logic        RESET_N,
  // Pins
  input crpr_cmd_t        CMD,
  input wire logic [15:0] DQ_OUT,
  input wire logic        DQ_OE,
  // Array side and status
  input wire logic        ARRAY_RD,
  input wire logic        ARRAY_WR,
  input wire logic        ARRAY_AUTOPRE,
  input wire logic        PATTERN_MODE
);
  // Command decode as the pins present it
  wire logic [2:0] op  = {CMD.ras_n, CMD.cas_n, CMD.we_n};
  wire logic       rd  = !CMD.cs_n && op == CMD_READ;
  wire logic       wr  = !CMD.cs_n && op == CMD_WRITE;
  wire logic       ms3 = !CMD.cs_n && op == CMD_MODE_SET && CMD.ba == MR_SEL_THREE;
  // First beat is registered at the latency edge, so it is seen one edge later
  localparam int OE_DLY = RD_LAT + 1;

  default clocking @(posedge MCLK); endclocking
  default disable iff (!RESET_N);

  // Mode entry and exit follow bit 2 of the mode set
  mode_enter_a: assert property (ms3 && CMD.addr[PAT_EN_BIT] |=> PATTERN_MODE)
    else $error("pattern mode not entered");
  mode_exit_a: assert property (ms3 && !CMD.addr[PAT_EN_BIT] |=> !PATTERN_MODE)
    else $error("pattern mode not left");
  // Pattern reads never touch the array, autoprecharge included
  pat_no_array_a: assert property (rd && PATTERN_MODE |=> !ARRAY_RD && !ARRAY_AUTOPRE)
    else $error("array accessed in pattern mode");
  no_autopre_a: assert property (PATTERN_MODE |=> !ARRAY_AUTOPRE)
    else $error("autoprecharge in pattern mode");
  normal_rd_a: assert property (rd && !PATTERN_MODE |=> ARRAY_RD &&
      ARRAY_AUTOPRE == $past(CMD.addr[AP_BIT]))
    else $error("normal read not sent to array");
  wr_route_a: assert property (wr |=> ARRAY_WR == !$past(PATTERN_MODE))
    else $error("write routed wrongly");
  // Same latency as an array read
  pat_latency_a: assert property (rd && PATTERN_MODE |-> ##OE_DLY DQ_OE)
    else $error("pattern data late");
  // Lanes mirror bit 0; guarded so forwarded array data is not judged
  lane_copy_a: assert property (DQ_OE && PATTERN_MODE && $past(PATTERN_MODE, 2) |->
      DQ_OUT[15:8] == DQ_OUT[7:0] &&
      DQ_OUT[7:1] == (REPLICATE ? {7{DQ_OUT[0]}} : 7'h00))
    else $error("lane bits not copied");
  burst_min_a: assert property ($rose(DQ_OE) && PATTERN_MODE |-> DQ_OE[*4])
    else $error("burst shorter than four beats");

  cover property (rd && PATTERN_MODE);
  cover property (rd && !PATTERN_MODE && CMD.addr[AP_BIT]);
  cover property ($rose(DQ_OE) && PATTERN_MODE);
endmodule

bind crpr_readout crpr_readout_asserts #(.RD_LAT(RD_LAT), .REPLICATE(REPLICATE)) u_chk (
  .MCLK(MCLK), .RESET_N(RESET_N), .CMD(CMD), .DQ_OUT(DQ_OUT), .DQ_OE(DQ_OE),
  .ARRAY_RD(ARRAY_RD), .ARRAY_WR(ARRAY_WR), .ARRAY_AUTOPRE(ARRAY_AUTOPRE),
  .PATTERN_MODE(PATTERN_MODE));

/* File: sim/crpr_ctrl_model.sv */
// Behavioural memory controller driving the command pins
`timescale 1ns/100ps
module crpr_ctrl_model
  import crpr_pkg::*;
(
  // Clock
  input wire logic clk,
  // Command pins
  output crpr_cmd_t cmd
);
  logic pat;

  // Deselected at time zero
  initial begin
    cmd = {1'b1, 20'h00000};
    pat = 1'b0;
  end

  // One command per edge; banks are never opened, so all stay idle
  task automatic send(input logic [2:0] op, input logic [2:0] ba, input logic [13:0] a);
    @(posedge clk);
    if (pat && op == CMD_READ) begin
      a[1:0] = 2'h0;
    end
    if (op == CMD_MODE_SET && ba == MR_SEL_THREE) begin
      pat = a[PAT_EN_BIT];
    end
    cmd <= {1'b0, op, ba, a};
  endtask

  // Release; address flips so a stale value never passes as valid
  task automatic idle();
    @(posedge clk);
    cmd.cs_n <= 1'b1;
    cmd.addr <= ~cmd.addr;
  endtask
endmodule

/* File: sim/tb.sv */
// Self-checking bench for the calibration pattern readout
`timescale 1ns/100ps
module tb;
  import crpr_pkg::*;
  localparam int LAT = 3;
  logic        MCLK, RESET_N, DQ_OE, ARRAY_RD, ARRAY_WR, ARRAY_AUTOPRE;
  logic        ARRAY_DQ_VLD, PATTERN_MODE;
  logic [15:0] DQ_IN, DQ_OUT, ARRAY_WDATA, ARRAY_DQ;
  crpr_cmd_t   CMD;
  logic [15:0] dq_out_zero;
  int          err_total, checked;

  crpr_readout #(.RD_LAT(LAT)) u_crpr_readout (.MCLK(MCLK), .RESET_N(RESET_N), .CMD(CMD),
    .DQ_IN(DQ_IN), .DQ_OUT(DQ_OUT), .DQ_OE(DQ_OE), .ARRAY_RD(ARRAY_RD),
    .ARRAY_WR(ARRAY_WR), .ARRAY_AUTOPRE(ARRAY_AUTOPRE), .ARRAY_WDATA(ARRAY_WDATA),
    .ARRAY_DQ(ARRAY_DQ), .ARRAY_DQ_VLD(ARRAY_DQ_VLD), .PATTERN_MODE(PATTERN_MODE));
  // Second copy with the upper lane bits driven low instead of copied
  crpr_readout #(.RD_LAT(LAT), .REPLICATE(1'b0)) u_crpr_readout_zero (.MCLK(MCLK),
    .RESET_N(RESET_N), .CMD(CMD), .DQ_IN(DQ_IN), .DQ_OUT(dq_out_zero), .DQ_OE(),
    .ARRAY_RD(), .ARRAY_WR(), .ARRAY_AUTOPRE(), .ARRAY_WDATA(), .ARRAY_DQ(ARRAY_DQ),
    .ARRAY_DQ_VLD(ARRAY_DQ_VLD), .PATTERN_MODE());
  crpr_ctrl_model u_crpr_ctrl_model (.clk(MCLK), .cmd(CMD));

  initial begin
    MCLK = 1'b0;
    forever #2.5 MCLK = ~MCLK;
  end

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  // One command, then look just after the edge that took it
  task automatic issue(input logic [2:0] op, input logic [2:0] ba, input logic [13:0] a);
    u_crpr_ctrl_model.send(op, ba, a);
    u_crpr_ctrl_model.idle();
    @(negedge MCLK);
  endtask

  task automatic burst(input logic [7:0] p, input int n, input int st);
    int w;
    w = 0;
    while (DQ_OE !== 1'b1 && w < 20) begin
      @(negedge MCLK);
      w++;
    end
    chk("latency", 16'(LAT), 16'(w));
    for (int i = 0; i < n; i++) begin
      chk("dq", {16{p[st+i]}}, DQ_OUT);
      chk("dq_zero", {7'h00, p[st+i], 7'h00, p[st+i]}, dq_out_zero);
      chk("oe", 16'h0001, {15'h0, DQ_OE});
      @(negedge MCLK);
    end
    chk("oe_end", 16'h0000, {15'h0, DQ_OE});
  endtask

  task automatic pat_case(input logic [1:0] bl, input logic [1:0] loc, input logic [13:0] a,
                          input logic [7:0] p, input int n, input int st);
    issue(CMD_MODE_SET, MR_SEL_ZERO, {12'h000, bl});
    issue(CMD_MODE_SET, MR_SEL_THREE, {11'h000, 1'b1, loc});
    chk("mode_on", 16'h0001, {15'h0, PATTERN_MODE});
    issue(CMD_READ, 3'h7, a);
    burst(p, n, st);
    issue(CMD_MODE_SET, MR_SEL_THREE, 14'h0000);
    chk("mode_off", 16'h0000, {15'h0, PATTERN_MODE});
  endtask

  task automatic t_normal();
    issue(CMD_MODE_SET, MR_SEL_THREE, 14'h0003);
    issue(CMD_READ, 3'h5, 14'h0400);
    chk("rd_ap", 16'h0003, {14'h0, ARRAY_RD, ARRAY_AUTOPRE});
    chk("fwd", 16'h5a3c, DQ_OUT);
    issue(CMD_WRITE, 3'h1, 14'h0008);
    chk("wr", 16'h0001, {15'h0, ARRAY_WR});
    chk("wdata", 16'hc3a5, ARRAY_WDATA);
  endtask

  task automatic t_calib();
    pat_case(BL_FIXED_EIGHT, 2'h0, 14'h0ff8, 8'haa, 8, 0);
    pat_case(BL_ON_THE_FLY, 2'h0, 14'h0ffc, 8'haa, 4, 4);
    pat_case(BL_ON_THE_FLY, 2'h0, 14'h1ff8, 8'haa, 8, 0);
    pat_case(BL_FIXED_FOUR, 2'h0, 14'h1ff8, 8'haa, 4, 0);
    for (int l = 1; l < 4; l++) begin
      pat_case(BL_FIXED_EIGHT, 2'(l), 14'h0ff8, PAT_RSVD, 8, 0);
    end
  endtask

  // Refused commands, overlapping reads and a reset in pattern mode
  task automatic t_refuse();
    int n;
    issue(CMD_MODE_SET, MR_SEL_THREE, 14'h0004);
    issue(CMD_WRITE, 3'h0, 14'h0000);
    chk("wr_pat", 16'h0000, {15'h0, ARRAY_WR});
    issue(CMD_READ, 3'h2, 14'h0400);
    chk("rda_pat", 16'h0000, {14'h0, ARRAY_RD, ARRAY_AUTOPRE});
    burst(8'haa, 8, 0);
    u_crpr_ctrl_model.send(CMD_READ, 3'h0, 14'h0000);
    u_crpr_ctrl_model.send(CMD_READ, 3'h0, 14'h0000);
    u_crpr_ctrl_model.idle();
    n = 0;
    repeat (LAT + 12) begin
      @(negedge MCLK);
      n += DQ_OE;
    end
    chk("b2b_len", 16'h0009, 16'(n));
    issue(CMD_READ, 3'h0, 14'h0000);
    // Short reset while the read is in the pipe, so a stale beat would show
    @(posedge MCLK) RESET_N <= 1'b0;
    @(posedge MCLK) RESET_N <= 1'b1;
    @(negedge MCLK);
    chk("rst", 16'h0000, {14'h0, PATTERN_MODE, DQ_OE});
    @(negedge MCLK);
    chk("rst_flush", 16'h5a3c, DQ_OUT);
    issue(CMD_READ, 3'h0, 14'h0000);
    chk("rd_after", 16'h0001, {15'h0, ARRAY_RD});
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Watchdog, well beyond the fewer than two hundred cycles the tests need
  initial begin
    #25000;
    err_total++;
    close_out();
  end

  // Array data held valid so any forwarding in pattern mode shows up
  initial begin
    RESET_N = 1'b0;
    DQ_IN = 16'hc3a5;
    ARRAY_DQ = 16'h5a3c;
    ARRAY_DQ_VLD = 1'b1;
    err_total = 0;
    checked = 0;
    repeat (2) @(posedge MCLK);
    RESET_N <= 1'b1;
    t_normal();
    t_calib();
    t_refuse();
    close_out();
  end
endmodule
